// ==== core/dcmt_consts.vh ====
`ifndef DCMT_CONSTS_VH
`define DCMT_CONSTS_VH

// Register indices; byte address is four times the index
`define DCMT_IDX_RUN   32'hffff83d0
`define DCMT_IDX_CSR0  32'hffff83d2
`define DCMT_IDX_CNT0  32'hffff83d4
`define DCMT_IDX_PER0  32'hffff83d6
`define DCMT_IDX_CSR1  32'hffff83d8
`define DCMT_IDX_CNT1  32'hffff83da
`define DCMT_IDX_PER1  32'hffff83dc
`define DCMT_IDX_IST   32'hffff83de
`define DCMT_IDX_IMSK  32'hffff83e0

// Control/status fields
`define DCMT_BIT_FLAG  7
`define DCMT_BIT_IE    6
`define DCMT_BIT_CKSH  1
`define DCMT_BIT_CKSL  0

// Reset values
`define DCMT_RST_ZERO  16'h0000
`define DCMT_RST_PER   16'hffff

// Prescaler width (divide by 512) and first tap width (divide by 8)
`define DCMT_PRE_W     9
`define DCMT_DIV8_W    3

`endif

// ==== core/dcmt_prescaler.v ====
`timescale 1ns/1ns
`include "dcmt_consts.vh"

module dcmt_prescaler (
  // Clock and reset
  input  wire       ref_clk_i,
  input  wire       init_i,
  // Divided ticks: /8, /32, /128, /512
  output wire [3:0] tick_o
);

  reg [`DCMT_PRE_W-1:0] pre_r;

  // Shared free-running divider keeps both channels phase-aligned
  always @(posedge ref_clk_i) begin
    if (init_i) begin
      pre_r <= {`DCMT_PRE_W{1'b0}};
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_tap
      assign tick_o[k] = &pre_r[`DCMT_DIV8_W + 2*k - 1:0];
    end
  endgenerate

endmodule

// ==== core/dcmt_chan.v ====
`timescale 1ns/1ns
`include "dcmt_consts.vh"

module dcmt_chan #(
  parameter W = 16
) (
  // Clock and initialisation
  input  wire         ref_clk_i,
  input  wire         init_i,
  // Selected tick, already gated by run
  input  wire         tick_i,
  input  wire [W-1:0] period_i,
  // Software write
  input  wire         wr_lo_i,
  input  wire         wr_hi_i,
  input  wire [W-1:0] wdata_i,
  // State
  output wire [W-1:0] cnt_o,
  output wire         match_o
);

  reg  [W-1:0] cnt_r;
  wire [W-1:0] merged;

  assign merged  = {wr_hi_i ? wdata_i[W-1:W/2] : cnt_r[W-1:W/2],
                    wr_lo_i ? wdata_i[W/2-1:0] : cnt_r[W/2-1:0]};
  assign match_o = tick_i && (cnt_r == period_i);
  assign cnt_o   = cnt_r;

  always @(posedge ref_clk_i) begin
    if (init_i) begin
      cnt_r <= `DCMT_RST_ZERO;
    end else if (match_o) begin
      cnt_r <= `DCMT_RST_ZERO;
    end else if (wr_lo_i || wr_hi_i) begin
      cnt_r <= merged;
    end else if (tick_i) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule

// ==== core/dcmt_timer.v ====
`timescale 1ns/1ns
`include "dcmt_consts.vh"

module dcmt_timer #(
  parameter AW = 12,
  parameter NCH = 2,
  parameter CW = 16
) (
  // Clock and resets
  input  wire          ref_clk_i,
  input  wire          nrst_i,
  input  wire          standby_i,
  input  wire          manual_rst_i,
  // Transfer controller flag clear strobes
  input  wire [NCH-1:0] dtc_clr_i,
  // APB slave
  input  wire          psel_i,
  input  wire          penable_i,
  input  wire          pwrite_i,
  input  wire [AW-1:0] paddr_i,
  input  wire [31:0]   pwdata_i,
  input  wire [3:0]    pstrb_i,
  output wire [31:0]   prdata_o,
  output wire          pready_o,
  output wire          pslverr_o,
  // Interrupts
  output wire [NCH-1:0] match_irq_request_o,
  output wire          irq_o
);

  localparam [31:0] I_RUN  = `DCMT_IDX_RUN;
  localparam [31:0] I_CSR0 = `DCMT_IDX_CSR0;
  localparam [31:0] I_CNT0 = `DCMT_IDX_CNT0;
  localparam [31:0] I_PER0 = `DCMT_IDX_PER0;
  localparam [31:0] I_CSR1 = `DCMT_IDX_CSR1;
  localparam [31:0] I_CNT1 = `DCMT_IDX_CNT1;
  localparam [31:0] I_PER1 = `DCMT_IDX_PER1;
  localparam [31:0] I_IST  = `DCMT_IDX_IST;
  localparam [31:0] I_IMSK = `DCMT_IDX_IMSK;

  // Power-on reset and standby share one initialise path
  wire init;
  assign init = !nrst_i || standby_i;

  // Manual reset comes from a pin; two flops keep a metastable edge out of the arm logic
  reg mrst_meta_r;
  reg mrst_sync_r;

  always @(posedge ref_clk_i) begin
    mrst_meta_r <= manual_rst_i;
    mrst_sync_r <= mrst_meta_r;
  end

  // Bus phases
  wire          setup;
  wire          access;
  wire          wen;
  wire          ren;
  wire [AW-3:0] adr;
  wire          lane_lo;
  wire          lane_hi;

  assign setup   = psel_i && !penable_i;
  assign access  = psel_i && penable_i;
  assign wen     = access && pwrite_i;
  assign ren     = access && !pwrite_i;
  assign adr     = paddr_i[AW-1:2];
  assign lane_lo = pstrb_i[0];
  assign lane_hi = pstrb_i[1];

  // Address hits
  wire hit_run;
  wire hit_ist;
  wire hit_imsk;
  wire [NCH-1:0] hit_csr;
  wire [NCH-1:0] hit_cnt;
  wire [NCH-1:0] hit_per;
  wire hit_any;

  assign hit_run  = (adr == I_RUN[AW-3:0]);
  assign hit_ist  = (adr == I_IST[AW-3:0]);
  assign hit_imsk = (adr == I_IMSK[AW-3:0]);
  assign hit_csr  = {adr == I_CSR1[AW-3:0], adr == I_CSR0[AW-3:0]};
  assign hit_cnt  = {adr == I_CNT1[AW-3:0], adr == I_CNT0[AW-3:0]};
  assign hit_per  = {adr == I_PER1[AW-3:0], adr == I_PER0[AW-3:0]};
  assign hit_any  = hit_run || hit_ist || hit_imsk ||
                    (|hit_csr) || (|hit_cnt) || (|hit_per);

  // Control and status state
  reg [NCH-1:0]   run_r;
  reg [NCH-1:0]   ie_r;
  reg [2*NCH-1:0] cks_r;
  reg [NCH-1:0]   flag_r;
  reg [NCH-1:0]   arm_r;
  reg [NCH*CW-1:0] per_r;
  reg [NCH-1:0]   ist_r;
  reg [NCH-1:0]   imsk_r;
  reg [31:0]      rdata_r;
  reg [31:0]      rdata_nxt;

  wire [NCH*CW-1:0] cnt;
  wire [NCH-1:0]    match;
  wire [3:0]        tick_div;

  dcmt_prescaler u_pre (
    .ref_clk_i (ref_clk_i),
    .init_i    (init),
    .tick_o    (tick_div)
  );

  // Run register
  always @(posedge ref_clk_i) begin
    if (init) begin
      run_r <= {NCH{1'b0}};
    end else if (wen && hit_run && lane_lo) begin
      run_r <= pwdata_i[NCH-1:0];
    end
  end

  // Local interrupt mask
  always @(posedge ref_clk_i) begin
    if (init) begin
      imsk_r <= {NCH{1'b0}};
    end else if (wen && hit_imsk && lane_lo) begin
      imsk_r <= pwdata_i[NCH-1:0];
    end
  end

  // Per-channel datapath
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
      wire [1:0]    sel;
      wire          tick;
      wire          csr_wlo;
      wire          clr_sw;
      wire          ist_w1c;
      wire [CW-1:0] per_cur;

      assign sel     = cks_r[2*ch+1:2*ch];
      assign per_cur = per_r[CW*ch+CW-1:CW*ch];

      // Stopped channel sees no tick, so it holds and never matches
      assign tick = run_r[ch] && tick_div[sel];

      assign csr_wlo = wen && hit_csr[ch] && lane_lo;
      // Clear only with a zero written after a read saw the flag set
      assign clr_sw  = csr_wlo && !pwdata_i[`DCMT_BIT_FLAG] && arm_r[ch];
      assign ist_w1c = wen && hit_ist && lane_lo && pwdata_i[ch];

      dcmt_chan #(
        .W (CW)
      ) u_chan (
        .ref_clk_i (ref_clk_i),
        .init_i    (init),
        .tick_i    (tick),
        .period_i  (per_cur),
        .wr_lo_i   (wen && hit_cnt[ch] && lane_lo),
        .wr_hi_i   (wen && hit_cnt[ch] && lane_hi),
        .wdata_i   (pwdata_i[CW-1:0]),
        .cnt_o     (cnt[CW*ch+CW-1:CW*ch]),
        .match_o   (match[ch])
      );

      // Enable and clock select fields
      always @(posedge ref_clk_i) begin
        if (init) begin
          ie_r[ch]            <= 1'b0;
          cks_r[2*ch+1:2*ch]  <= 2'h0;
        end else if (csr_wlo) begin
          ie_r[ch]            <= pwdata_i[`DCMT_BIT_IE];
          cks_r[2*ch+1:2*ch]  <= pwdata_i[`DCMT_BIT_CKSH:`DCMT_BIT_CKSL];
        end
      end

      // Match flag: a new match wins over any clear in the same cycle
      always @(posedge ref_clk_i) begin
        if (init) begin
          flag_r[ch] <= 1'b0;
        end else if (match[ch]) begin
          flag_r[ch] <= 1'b1;
        end else if (clr_sw || dtc_clr_i[ch]) begin
          flag_r[ch] <= 1'b0;
        end
      end

      // Read-then-write arming; a write of 1 just disarms
      always @(posedge ref_clk_i) begin
        if (init || mrst_sync_r) begin
          arm_r[ch] <= 1'b0;
        end else if (csr_wlo) begin
          arm_r[ch] <= 1'b0;
        end else if (ren && hit_csr[ch] && rdata_r[`DCMT_BIT_FLAG]) begin
          arm_r[ch] <= 1'b1;
        end else if (!flag_r[ch]) begin
          arm_r[ch] <= 1'b0;
        end
      end

      // Period register, byte-lane writable
      always @(posedge ref_clk_i) begin
        if (init) begin
          per_r[CW*ch+CW-1:CW*ch] <= `DCMT_RST_PER;
        end else if (wen && hit_per[ch]) begin
          if (lane_lo) begin
            per_r[CW*ch+CW/2-1:CW*ch] <= pwdata_i[CW/2-1:0];
          end
          if (lane_hi) begin
            per_r[CW*ch+CW-1:CW*ch+CW/2] <= pwdata_i[CW-1:CW/2];
          end
        end
      end

      // Sticky event status, write one to clear, set wins
      always @(posedge ref_clk_i) begin
        if (init) begin
          ist_r[ch] <= 1'b0;
        end else if (match[ch]) begin
          ist_r[ch] <= 1'b1;
        end else if (ist_w1c) begin
          ist_r[ch] <= 1'b0;
        end
      end

      assign match_irq_request_o[ch] = flag_r[ch] && ie_r[ch];
    end
  endgenerate

  // Manual reset reaches only the read-arm state; no timer register sees it

  // Read mux; reserved bits stay zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (hit_run) begin
      rdata_nxt[NCH-1:0] = run_r;
    end
    if (hit_ist) begin
      rdata_nxt[NCH-1:0] = ist_r;
    end
    if (hit_imsk) begin
      rdata_nxt[NCH-1:0] = imsk_r;
    end
    if (hit_csr[0]) begin
      rdata_nxt[`DCMT_BIT_FLAG] = flag_r[0];
      rdata_nxt[`DCMT_BIT_IE]   = ie_r[0];
      rdata_nxt[`DCMT_BIT_CKSH:`DCMT_BIT_CKSL] = cks_r[1:0];
    end
    if (hit_csr[1]) begin
      rdata_nxt[`DCMT_BIT_FLAG] = flag_r[1];
      rdata_nxt[`DCMT_BIT_IE]   = ie_r[1];
      rdata_nxt[`DCMT_BIT_CKSH:`DCMT_BIT_CKSL] = cks_r[3:2];
    end
    if (hit_cnt[0]) begin
      rdata_nxt[CW-1:0] = cnt[CW-1:0];
    end
    if (hit_cnt[1]) begin
      rdata_nxt[CW-1:0] = cnt[2*CW-1:CW];
    end
    if (hit_per[0]) begin
      rdata_nxt[CW-1:0] = per_r[CW-1:0];
    end
    if (hit_per[1]) begin
      rdata_nxt[CW-1:0] = per_r[2*CW-1:CW];
    end
  end

  // Read data captured in the setup cycle so the access phase needs no wait.
  // Trade-off: a counter read shows the value one cycle before completion.
  always @(posedge ref_clk_i) begin
    if (init) begin
      rdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign prdata_o  = rdata_r;
  assign pready_o  = 1'b1;
  assign pslverr_o = access && !hit_any;
  assign irq_o     = |(ist_r & imsk_r);

endmodule

// ==== sim/dcmt_timer_properties.sv ====
`timescale 1ns/1ns
module dcmt_props #(
  parameter AW  = 12,
  parameter NCH = 2
) (
  // Clock and resets
  input wire logic           ref_clk_i,
  input wire logic           nrst_i,
  input wire logic           standby_i,
  input wire logic [NCH-1:0] dtc_clr_i,
  // APB
  input wire logic           psel_i,
  input wire logic           penable_i,
  input wire logic           pwrite_i,
  input wire logic [AW-1:0]  paddr_i,
  input wire logic [31:0]    pwdata_i,
  input wire logic [3:0]     pstrb_i,
  input wire logic [31:0]    prdata_o,
  input wire logic           pready_o,
  input wire logic           pslverr_o,
  // Interrupts
  input wire logic [NCH-1:0] match_irq_request_o,
  input wire logic           irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  wire rd_acc = psel_i && penable_i && !pwrite_i;
  wire wr_acc = psel_i && penable_i && pwrite_i && pstrb_i[0];
  wire init   = standby_i || !nrst_i;
  wire cause0 = init || dtc_clr_i[0] || (wr_acc && paddr_i == 12'hf48);
  wire cause1 = init || dtc_clr_i[1] || (wr_acc && paddr_i == 12'hf60);
  wire icause = init || (wr_acc && (paddr_i == 12'hf78 || paddr_i == 12'hf80));
  sequence s_ien_off0;
    wr_acc && paddr_i == 12'hf48 && !pwdata_i[6];
  endsequence
  sequence s_mask_off;
    wr_acc && paddr_i == 12'hf80 && pwdata_i[1:0] == 2'b00;
  endsequence
  AST_READY: assert property (pready_o) else $error("ready low");
  AST_ERR_UNMAP: assert property (psel_i && penable_i && paddr_i == 12'h000 |-> pslverr_o)
    else $error("no error on unmapped access");
  AST_HI_ZERO: assert property (rd_acc |-> prdata_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_RUN_RSV: assert property (rd_acc && paddr_i == 12'hf40 |-> prdata_o[15:2] == 14'h0)
    else $error("run reserved bits set");
  AST_CSR_RSV: assert property (rd_acc && (paddr_i == 12'hf48 || paddr_i == 12'hf60)
    |-> prdata_o[15:8] == 8'h00 && prdata_o[5:2] == 4'h0) else $error("csr reserved set");
  AST_IEN_OFF: assert property (s_ien_off0 |=> !match_irq_request_o[0])
    else $error("request with enable clear");
  AST_REQ0_FALL: assert property ($fell(match_irq_request_o[0]) |-> $past(cause0))
    else $error("request 0 dropped without cause");
  AST_REQ1_FALL: assert property ($fell(match_irq_request_o[1]) |-> $past(cause1))
    else $error("request 1 dropped without cause");
  AST_MASK_OFF: assert property (s_mask_off |=> !irq_o) else $error("masked irq high");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(icause))
    else $error("irq dropped without cause");
  AST_STBY: assert property (standby_i |=> match_irq_request_o == '0 && !irq_o
    && prdata_o == 32'h0) else $error("standby did not initialise");
endmodule

bind dcmt_timer dcmt_props #(.AW(AW), .NCH(NCH)) u_props (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .standby_i(standby_i), .dtc_clr_i(dtc_clr_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .match_irq_request_o(match_irq_request_o), .irq_o(irq_o));

// ==== sim/tb_dual_compare_match_timer.sv ====
`timescale 1ns/1ns
module tb_dual_compare_match_timer;
  logic        ref_clk_i    = 1'b0;
  logic        nrst_i       = 1'b0;
  logic        standby_i    = 1'b0;
  logic        manual_rst_i = 1'b0;
  logic [1:0]  dtc_clr_i    = 2'b00;
  logic        psel_i       = 1'b0;
  logic        penable_i    = 1'b0;
  logic        pwrite_i     = 1'b0;
  logic [11:0] paddr_i      = 12'h000;
  logic [31:0] pwdata_i     = 32'h0;
  logic [3:0]  pstrb_i      = 4'h0;
  wire  [31:0] prdata_o;
  wire         pready_o;
  wire         pslverr_o;
  wire  [1:0]  match_irq_request_o;
  wire         irq_o;
  logic [31:0] rdat;
  logic [31:0] held;
  logic        rerr;
  int          err_count = 0;
  int          checked   = 0;
  // Byte address is four times the register index, cut to the decoded bits
  localparam [11:0] RUN = 12'hf40, CSR0 = 12'hf48, CNT0 = 12'hf50, PER0 = 12'hf58;
  localparam [11:0] CSR1 = 12'hf60, CNT1 = 12'hf68, PER1 = 12'hf70, IST = 12'hf78;
  localparam [11:0] IMSK = 12'hf80;

  always #10 ref_clk_i = ~ref_clk_i;

  dcmt_timer dut_u (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .standby_i(standby_i),
    .manual_rst_i(manual_rst_i), .dtc_clr_i(dtc_clr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .match_irq_request_o(match_irq_request_o), .irq_o(irq_o));

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge ref_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    pstrb_i   <= s;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'h3);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk(rdat, e);
  endtask

  task automatic wait_req(input int ch);
    int i = 0;
    while (match_irq_request_o[ch] !== 1'b1 && i < 2000) begin
      @(posedge ref_clk_i);
      i++;
    end
    chk({31'h0, match_irq_request_o[ch]}, 32'h1);
  endtask

  task complete_run;
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    complete_run;
  end

  initial begin
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(RUN, 32'h0);
    rd(CSR0, 32'h0);
    rd(CNT0, 32'h0);
    rd(PER0, 32'hffff);
    rd(CSR1, 32'h0);
    rd(CNT1, 32'h0);
    rd(PER1, 32'hffff);
    wr(CSR0, 32'hffff);
    rd(CSR0, 32'h43);
    wr(RUN, 32'hfffc);
    rd(RUN, 32'h0);
    // Period 2 on the fastest tap, enabled and unmasked
    wr(PER0, 32'h2);
    wr(IMSK, 32'h1);
    wr(CSR0, 32'h40);
    wr(RUN, 32'h1);
    wait_req(0);
    chk({31'h0, irq_o}, 32'h1);
    // Stop first so a fresh match cannot race the flag clear
    wr(RUN, 32'h0);
    // A zero written with no read before it must leave the flag set
    wr(CSR0, 32'h0);
    @(posedge ref_clk_i);
    chk({31'h0, match_irq_request_o[0]}, 32'h0);
    wr(CSR0, 32'h40);
    @(posedge ref_clk_i);
    chk({31'h0, match_irq_request_o[0]}, 32'h1);
    rd(IST, 32'h1);
    rd(CSR0, 32'hc0);
    wr(CSR0, 32'hc0);
    wr(CSR0, 32'h40);
    rd(CSR0, 32'hc0);
    wr(CSR0, 32'h40);
    rd(CSR0, 32'h40);
    chk({31'h0, match_irq_request_o[0]}, 32'h0);
    xfer(1'b0, CNT0, 32'h0, 4'h0);
    held = rdat;
    repeat (100) @(posedge ref_clk_i);
    rd(CNT0, held);
    rd(CSR0, 32'h40);
    wr(IST, 32'h1);
    @(posedge ref_clk_i);
    chk({31'h0, irq_o}, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(CSR1, k);
      wr(CNT1, 32'h0);
      wr(RUN, 32'h2);
      repeat (4 * (8 << (2 * k))) @(posedge ref_clk_i);
      wr(RUN, 32'h0);
      xfer(1'b0, CNT1, 32'h0, 4'h0);
      chk({31'h0, rdat >= 32'h4 && rdat <= 32'h5}, 32'h1);
    end
    wr(CNT1, 32'h1234);
    xfer(1'b1, CNT1, 32'h0000ab00, 4'h2);
    rd(CNT1, 32'hab34);
    xfer(1'b1, CNT1, 32'h000000cd, 4'h1);
    rd(CNT1, 32'habcd);
    wr(PER1, 32'h1);
    wr(CNT1, 32'h0);
    wr(CSR1, 32'h40);
    wr(RUN, 32'h2);
    wait_req(1);
    chk({30'h0, match_irq_request_o}, 32'h2);
    wr(RUN, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    @(posedge ref_clk_i);
    dtc_clr_i <= 2'b10;
    @(posedge ref_clk_i);
    dtc_clr_i <= 2'b00;
    @(posedge ref_clk_i);
    chk({30'h0, match_irq_request_o}, 32'h0);
    xfer(1'b0, 12'h000, 32'h0, 4'h0);
    chk({rdat[31:1], rerr}, 32'h1);
    wr(IMSK, 32'h0);
    @(posedge ref_clk_i);
    manual_rst_i <= 1'b1;
    @(posedge ref_clk_i);
    manual_rst_i <= 1'b0;
    rd(PER0, 32'h2);
    rd(CSR1, 32'h40);
    @(posedge ref_clk_i);
    standby_i <= 1'b1;
    @(posedge ref_clk_i);
    standby_i <= 1'b0;
    rd(PER0, 32'hffff);
    rd(CNT1, 32'h0);
    rd(CSR1, 32'h0);
    complete_run;
  end
endmodule
